//--- design/selhc_defs.vh
// Constants for the stop-exit and limp-home control block
`ifndef SELHC_DEFS_VH
`define SELHC_DEFS_VH
`define SELHC_ADDR_W 12
`define SELHC_OFF_CTRL 12'h000
`define SELHC_OFF_SLOW 12'h004
`define SELHC_OFF_STAT 12'h008
`define SELHC_B_NOLH 0
`define SELHC_B_CME 1
`define SELHC_B_FORCED_CLOCK_MONITOR_ENABLE 2
`define SELHC_B_DLY 3
`define SELHC_B_PSEUDO_STOP_BIT 4
`define SELHC_B_PLL_ON_BIT 5
`define SELHC_B_PLL_BUS_CLOCK_SELECT 6
`define SELHC_B_MCS 7
`define SELHC_B_LIMP_HOME_INTERRUPT_ENABLE 8
`define SELHC_B_AUTO 9
`define SELHC_CTRL_W 10
`define SELHC_CTRL_RST 10'h022
`define SELHC_SLOW_W 6
`define SELHC_SLOW_RST 6'h00
`define SELHC_B_LIMP_HOME_STATUS_FLAG 0
`define SELHC_B_LIMP_HOME_INTERRUPT_FLAG 1
`define SELHC_B_STOP 2
`define SELHC_B_PSEUDO 3
`define SELHC_B_LIMP 4
`define SELHC_CNT_W 13
`define SELHC_CNT_MID 13'h0FFF
`endif

//--- design/selhc_ctrl.v
// Stop entry, stop exit delay and limp-home sequencing with APB registers
// Functional notes
// - Stop instruction enters stop; recovery chosen by no-limp-home, monitor enable, delay.
// - Delay bit set: 4096-count wait before full release; cleared: no wait.
// - Delay counter advances on the slow-divided module clock enable.
// - Wake on reset, interrupt pins, key wake-up J or H, CAN wake-up.
// - No limp-home, monitors off: resume on external clock after 4096 counts with delay bit set, at once without.
// - No limp-home, monitor on: stop instruction raises clock-monitor reset.
// - Limp-home allowed: monitor masked in stop, limp-home with monitor on.
// - Limp-home delay: external clock seen at 4096 leaves limp-home and exits.
// - No clock at 4096: exit in limp-home, status and interrupt flags set.
// - In limp-home, monitor sampled each time counter reaches 4096.
// - Clock seen: leave limp-home, clear status, set flag, request if enabled.
// - Limp-home, no delay, crystal: release at once on limp-home clock.
// - On leaving limp-home, bus and module clock selects return to their current register values.
// - Clean external clock, no delay: release at once, status flag never set.
// - Pseudo-stop bit set: stop keeps oscillator running at low amplitude.
// - Pseudo-stop shares wake events and delay behaviour with stop.
// - Limp-home forces PLL-on and bus select high, module select low.
// - Reset sets monitor enable and PLL-on, clears no-limp-home.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "selhc_defs.vh"
module selhc_ctrl (
	input wire clock,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`SELHC_ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire stop_instr,
	input wire irq_pin,
	input wire nonmaskable_interrupt_pin,
	input wire key_wake_j,
	input wire key_wake_h,
	input wire can_wake,
	input wire ext_clock_present,
	output reg cpu_run,
	output reg key_blocks_run,
	output reg osc_run,
	output reg osc_low_amp,
	output reg clock_monitor_reset,
	output reg monitor_active,
	output reg limp_home_mode,
	output reg pll_on_out,
	output reg pll_bus_clock_select_out,
	output reg module_clock_select_out,
	output reg limp_home_irq
);
	reg [`SELHC_CTRL_W-1:0] ctrl_q;
	reg [`SELHC_SLOW_W-1:0] slow_q;
	reg [`SELHC_SLOW_W-1:0] div_q;
	reg [`SELHC_CNT_W-1:0] cnt_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg pseudo_q;
	reg pseudo_d;
	reg limp_q;
	reg limp_d;
	reg limp_home_status_flag_q;
	reg limp_home_status_flag_d;
	reg limp_home_interrupt_flag_q;
	reg limp_home_interrupt_flag_set;
	reg cnt_clr;
	reg cmr_d;
	reg [31:0] rdata;
	reg map_hit;
	wire no_limp_home_bit;
	wire monitor_en_bits;
	wire stop_exit_delay_bit;
	wire pseudo_stop_bit;
	wire limp_home_interrupt_enable;
	wire wake;
	wire slow_divided_module_clock_tick;
	wire mid_tick;
	wire wr_en;
	wire setup;
	localparam [1:0] ST_RUN = 2'h0;
	localparam [1:0] ST_STOP = 2'h1;
	localparam [1:0] ST_DELAY = 2'h2;

	assign no_limp_home_bit = ctrl_q[`SELHC_B_NOLH];
	assign monitor_en_bits = ctrl_q[`SELHC_B_CME] | ctrl_q[`SELHC_B_FORCED_CLOCK_MONITOR_ENABLE];
	assign stop_exit_delay_bit = ctrl_q[`SELHC_B_DLY];
	assign pseudo_stop_bit = ctrl_q[`SELHC_B_PSEUDO_STOP_BIT];
	assign limp_home_interrupt_enable = ctrl_q[`SELHC_B_LIMP_HOME_INTERRUPT_ENABLE];
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;

	// Any wake source ends stop and pseudo-stop alike
	assign wake = irq_pin | nonmaskable_interrupt_pin | key_wake_j
		| key_wake_h | can_wake;

	// Slow divider gives one enable pulse every slow_q+1 module clock periods
	assign slow_divided_module_clock_tick = (div_q == slow_q);
	assign mid_tick = slow_divided_module_clock_tick & (cnt_q == `SELHC_CNT_MID);

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			div_q <= `SELHC_SLOW_RST;
		end else if (slow_divided_module_clock_tick) begin
			div_q <= `SELHC_SLOW_RST;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// 13-stage counter on the module clock enable, cleared on each wake from stop
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			cnt_q <= {`SELHC_CNT_W{1'b0}};
		end else if (cnt_clr) begin
			cnt_q <= {`SELHC_CNT_W{1'b0}};
		end else if (slow_divided_module_clock_tick) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Sequencer for stop entry, wake and exit delay
	always @* begin
		state_d = state_q;
		pseudo_d = pseudo_q;
		limp_d = limp_q;
		limp_home_status_flag_d = limp_home_status_flag_q;
		limp_home_interrupt_flag_set = 1'b0;
		cnt_clr = 1'b0;
		cmr_d = 1'b0;
		case (state_q)
			ST_RUN: begin
				if (stop_instr) begin
					if (no_limp_home_bit & monitor_en_bits) begin
						cmr_d = 1'b1;
					end else begin
						state_d = ST_STOP;
						pseudo_d = pseudo_stop_bit;
					end
				end else if (limp_q & mid_tick & ext_clock_present) begin
					limp_d = 1'b0;
					limp_home_status_flag_d = 1'b0;
					limp_home_interrupt_flag_set = 1'b1;
				end
			end
			ST_STOP: begin
				if (wake) begin
					cnt_clr = 1'b1;
					if (stop_exit_delay_bit) begin
						state_d = ST_DELAY;
						limp_d = ~no_limp_home_bit;
					end else begin
						state_d = ST_RUN;
						pseudo_d = 1'b0;
						if (~no_limp_home_bit & ~ext_clock_present) begin
							limp_d = 1'b1;
							limp_home_status_flag_d = 1'b1;
							limp_home_interrupt_flag_set = 1'b1;
						end
						// Clean external clock: no limp-home, flag untouched
					end
				end
			end
			ST_DELAY: begin
				if (mid_tick) begin
					state_d = ST_RUN;
					pseudo_d = 1'b0;
					if (limp_q) begin
						if (ext_clock_present) begin
							limp_d = 1'b0;
						end else begin
							limp_home_status_flag_d = 1'b1;
							limp_home_interrupt_flag_set = 1'b1;
						end
					end
				end
			end
			default: begin
				state_d = ST_RUN;
				pseudo_d = 1'b0;
			end
		endcase
	end

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			state_q <= ST_RUN;
			pseudo_q <= 1'b0;
			limp_q <= 1'b0;
			limp_home_status_flag_q <= 1'b0;
		end else begin
			state_q <= state_d;
			pseudo_q <= pseudo_d;
			limp_q <= limp_d;
			limp_home_status_flag_q <= limp_home_status_flag_d;
		end
	end

	// Control and slow divider registers, reset defaults enable limp-home
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ctrl_q <= `SELHC_CTRL_RST;
			slow_q <= `SELHC_SLOW_RST;
		end else if (wr_en) begin
			if (paddr == `SELHC_OFF_CTRL) begin
				// Bus select stays writable in limp-home
				ctrl_q <= pwdata[`SELHC_CTRL_W-1:0];
			end
			if (paddr == `SELHC_OFF_SLOW) begin
				slow_q <= pwdata[`SELHC_SLOW_W-1:0];
			end
		end
	end

	// Limp-home interrupt flag, write one to clear, set wins
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			limp_home_interrupt_flag_q <= 1'b0;
		end else if (limp_home_interrupt_flag_set) begin
			limp_home_interrupt_flag_q <= 1'b1;
		end else if (wr_en & (paddr == `SELHC_OFF_STAT)
			& pwdata[`SELHC_B_LIMP_HOME_INTERRUPT_FLAG]) begin
			limp_home_interrupt_flag_q <= 1'b0;
		end
	end

	// Read mux
	always @* begin
		rdata = 32'h0000_0000;
		map_hit = 1'b1;
		case (paddr)
			`SELHC_OFF_CTRL: begin
				rdata[`SELHC_CTRL_W-1:0] = ctrl_q;
			end
			`SELHC_OFF_SLOW: begin
				rdata[`SELHC_SLOW_W-1:0] = slow_q;
			end
			`SELHC_OFF_STAT: begin
				rdata[`SELHC_B_LIMP_HOME_STATUS_FLAG] = limp_home_status_flag_q;
				rdata[`SELHC_B_LIMP_HOME_INTERRUPT_FLAG] = limp_home_interrupt_flag_q;
				rdata[`SELHC_B_STOP] = (state_q != ST_RUN);
				rdata[`SELHC_B_PSEUDO] = pseudo_q;
				rdata[`SELHC_B_LIMP] = limp_q;
			end
			default: begin
				map_hit = 1'b0;
			end
		endcase
	end

	// APB slave, one wait-free access phase after setup
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata;
				pslverr <= ~map_hit;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// Clock-unit outputs, registered from next-state values
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			cpu_run <= 1'b1;
			key_blocks_run <= 1'b1;
			osc_run <= 1'b1;
			osc_low_amp <= 1'b0;
			clock_monitor_reset <= 1'b0;
			monitor_active <= 1'b1;
			limp_home_mode <= 1'b0;
			pll_on_out <= 1'b1;
			pll_bus_clock_select_out <= 1'b0;
			module_clock_select_out <= 1'b0;
			limp_home_irq <= 1'b0;
		end else begin
			cpu_run <= (state_d == ST_RUN);
			key_blocks_run <= (state_d != ST_STOP);
			osc_run <= (state_d != ST_STOP) | pseudo_d;
			osc_low_amp <= (state_d == ST_STOP) & pseudo_d;
			clock_monitor_reset <= cmr_d;
			// Monitor masked in stop when limp-home allowed
			monitor_active <= limp_d | (monitor_en_bits
				& ~((state_d == ST_STOP) & ~no_limp_home_bit));
			limp_home_mode <= limp_d;
			// Forced selects in limp-home, register values otherwise
			pll_on_out <= limp_d | ctrl_q[`SELHC_B_PLL_ON_BIT];
			pll_bus_clock_select_out <= limp_d | ctrl_q[`SELHC_B_PLL_BUS_CLOCK_SELECT];
			module_clock_select_out <= ~limp_d & ctrl_q[`SELHC_B_MCS];
			limp_home_irq <= (limp_home_interrupt_flag_set | limp_home_interrupt_flag_q) & limp_home_interrupt_enable;
		end
	end
endmodule

//--- verification/selhc_chk.sv
// Port checker for the stop-exit and limp-home control block
`timescale 1ns/1ps
module selhc_chk (
	input wire clock,
	input wire reset,
	input wire stop_instr,
	input wire irq_pin,
	input wire nonmaskable_interrupt_pin,
	input wire key_wake_j,
	input wire key_wake_h,
	input wire can_wake,
	input wire cpu_run,
	input wire key_blocks_run,
	input wire osc_run,
	input wire osc_low_amp,
	input wire clock_monitor_reset,
	input wire monitor_active,
	input wire limp_home_mode,
	input wire pll_on_out,
	input wire pll_bus_clock_select_out,
	input wire module_clock_select_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	property p_entry; $fell(key_blocks_run) |-> $past(stop_instr); endproperty
	a_entry: assert property (p_entry) else $error("stop entered without stop request");
	property p_wake; !key_blocks_run && (irq_pin || nonmaskable_interrupt_pin || key_wake_j
		|| key_wake_h || can_wake) |=> key_blocks_run; endproperty
	a_wake: assert property (p_wake) else $error("wake event did not end stop");
	property p_keyfirst; !key_blocks_run |-> !cpu_run; endproperty
	a_keyfirst: assert property (p_keyfirst) else $error("cpu runs in stop");
	property p_dmin; $rose(key_blocks_run) && !cpu_run |=> !cpu_run [*8]; endproperty
	a_dmin: assert property (p_dmin) else $error("exit wait cut short");
	property p_cmr; clock_monitor_reset |-> cpu_run ##1 !clock_monitor_reset; endproperty
	a_cmr: assert property (p_cmr) else $error("monitor reset pulse wrong");
	property p_lh; limp_home_mode |-> pll_on_out && pll_bus_clock_select_out
		&& !module_clock_select_out; endproperty
	a_lh: assert property (p_lh) else $error("limp-home selects not forced");
	property p_mon; limp_home_mode |-> monitor_active; endproperty
	a_mon: assert property (p_mon) else $error("monitor off in limp-home");
	property p_osc; !key_blocks_run |-> osc_run == osc_low_amp; endproperty
	a_osc: assert property (p_osc) else $error("oscillator state wrong in stop");
endmodule
bind selhc_ctrl selhc_chk u_selhc_chk (.clock, .reset, .stop_instr, .irq_pin,
	.nonmaskable_interrupt_pin, .key_wake_j, .key_wake_h, .can_wake, .cpu_run,
	.key_blocks_run, .osc_run, .osc_low_amp, .clock_monitor_reset, .monitor_active,
	.limp_home_mode, .pll_on_out, .pll_bus_clock_select_out, .module_clock_select_out);

//--- verification/selhc_xsrc.sv
// Model of the external clock source and the wake-up sources
`timescale 1ns/1ps
module selhc_xsrc (
	input wire clock,
	input wire reset,
	input wire clk_ok,
	input wire [4:0] wake_req,
	output reg ext_clock_present,
	output reg [4:0] wake
);
	// Monitor sees the oscillator one cycle late
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			ext_clock_present <= 1'b1;
			wake <= 5'h00;
		end else begin
			ext_clock_present <= clk_ok;
			wake <= wake_req;
		end
	end
endmodule

//--- verification/tb_top.sv
// Testbench for stop exit delay and limp-home sequencing
`timescale 1ns/1ps
`include "selhc_defs.vh"
module tb_top;
	reg clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, stop_instr = 0, clk_ok = 1, e;
	reg [`SELHC_ADDR_W-1:0] paddr = 0;
	reg [31:0] pwdata = 0, rv;
	reg [4:0] wreq = 0;
	reg [5:0] snap;
	wire [4:0] wk;
	wire [31:0] prdata;
	wire pready, pslverr, ecp, cpu_run, key_blocks_run, osc_run, osc_low_amp, clock_monitor_reset;
	wire monitor_active, limp_home_mode, pll_on_out, bsel, msel, limp_home_irq;
	integer bad_count = 0, checks = 0, cyc = 0, n, i;
	always #5 clock = ~clock;
	selhc_xsrc u_selhc_xsrc (.clock, .reset, .clk_ok, .wake_req(wreq), .ext_clock_present(ecp),
		.wake(wk));
	selhc_ctrl u_selhc_ctrl (.clock, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .stop_instr, .irq_pin(wk[0]), .nonmaskable_interrupt_pin(wk[1]),
		.key_wake_j(wk[2]), .key_wake_h(wk[3]), .can_wake(wk[4]), .ext_clock_present(ecp),
		.cpu_run, .key_blocks_run, .osc_run, .osc_low_amp, .clock_monitor_reset, .monitor_active,
		.limp_home_mode, .pll_on_out, .pll_bus_clock_select_out(bsel),
		.module_clock_select_out(msel), .limp_home_irq);
	task print_verdict;
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input string nm, input [31:0] ex, input [31:0] got);
		checks = checks + 1;
		if (got !== ex) begin
			bad_count = bad_count + 1;
			$display("[ERR] %s exp %h got %h", nm, ex, got);
		end
	endtask
	task apb(input w, input [`SELHC_ADDR_W-1:0] a, input [31:0] d);
		@(posedge clock);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rv = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Stop, snapshot, wake, then count cycles until the cpu runs
	task sw(input [4:0] w);
		@(posedge clock);
		stop_instr <= 1;
		@(posedge clock);
		stop_instr <= 0;
		@(posedge clock);
		snap = {monitor_active, cpu_run, clock_monitor_reset, key_blocks_run, osc_run,
			osc_low_amp};
		wreq <= w;
		@(posedge clock);
		wreq <= 0;
		n = 0;
		while (cpu_run !== 1'b1) begin
			@(posedge clock);
			n = n + 1;
		end
		repeat (2) @(posedge clock);
	endtask
	always @(posedge clock) begin
		cyc = cyc + 1;
		if (cyc == 60000) begin
			bad_count = bad_count + 1;
			print_verdict;
		end
	end
	initial begin
		repeat (4) @(posedge clock);
		reset <= 0;
		apb(0, `SELHC_OFF_CTRL, 0);
		chk("ctrl", 32'h0000_0022, rv);
		apb(0, 12'h00C, 0);
		chk("unmap", 32'h0000_0001, {rv[30:0], e});
		apb(1, `SELHC_OFF_CTRL, 32'h0000_0023);
		sw(5'h01);
		chk("cmr", 6'h3E, snap);
		for (i = 0; i < 5; i = i + 1) begin
			apb(1, `SELHC_OFF_CTRL, 32'h0000_0020 | (i & 1));
			sw(5'h01 << i);
			chk("stop", 6'h00, snap);
			chk("fast", 1, n < 6);
			apb(0, `SELHC_OFF_STAT, 0);
			chk("limp_home_status_flag", 0, rv & 32'h0000_0013);
		end
		apb(1, `SELHC_OFF_SLOW, 1);
		apb(1, `SELHC_OFF_CTRL, 32'h0000_0029);
		sw(5'h10);
		chk("slow", 1, n >= 8192 && n <= 8200 && !limp_home_mode);
		apb(1, `SELHC_OFF_SLOW, 0);
		apb(1, `SELHC_OFF_CTRL, 32'h0000_01FA);
		clk_ok <= 0;
		sw(5'h02);
		chk("pstop", 6'h03, snap);
		chk("dly", 1, n >= 4096 && n <= 4104);
		chk("limp", 6'h3D, {limp_home_mode, monitor_active, pll_on_out, bsel, msel,
			limp_home_irq});
		apb(0, `SELHC_OFF_STAT, 0);
		chk("stat", 32'h0000_0013, rv & 32'h0000_0013);
		clk_ok <= 1;
		n = 0;
		while (limp_home_mode !== 1'b0 && n < 8300) begin
			@(posedge clock);
			n = n + 1;
		end
		repeat (2) @(posedge clock);
		chk("back", 4'hF, {n < 8300, bsel, msel, limp_home_irq});
		apb(0, `SELHC_OFF_STAT, 0);
		chk("stat", 32'h0000_0002, rv & 32'h0000_0013);
		apb(1, `SELHC_OFF_STAT, 32'h0000_0002);
		apb(0, `SELHC_OFF_STAT, 0);
		chk("w1c", 0, {rv[1], limp_home_irq});
		apb(1, `SELHC_OFF_CTRL, 32'h0000_0028);
		sw(5'h04);
		chk("xtal", 1, n >= 4096 && n <= 4104 && !limp_home_mode);
		apb(1, `SELHC_OFF_CTRL, 32'h0000_0060);
		clk_ok <= 0;
		sw(5'h08);
		chk("fastlh", 1, n < 6 && limp_home_mode);
		chk("noirq", 0, limp_home_irq);
		apb(1, `SELHC_OFF_CTRL, 32'h0000_0020);
		repeat (2) @(posedge clock);
		chk("force", 1, bsel);
		clk_ok <= 1;
		n = 0;
		while (limp_home_mode !== 1'b0 && n < 8300) begin
			@(posedge clock);
			n = n + 1;
		end
		repeat (2) @(posedge clock);
		chk("pll", 2'b10, {n < 8300, bsel});
		print_verdict;
	end
endmodule
